// ---- bench/chgmon_pins_host.sv ----
// Lamp and host model on the two open-collector status pins.
// Assumes oe high means the charger sinks the pin; pull-ups elsewhere.
`timescale 1ns/1ps
module chgmon_pins_host
(
  // Charger side
  input  wire logic i_oe_a,
  input  wire logic i_oe_b,
  // Pin levels seen by the host
  output logic      o_pin_a,
  output logic      o_pin_b
);
  // Pulled up when released, low while sunk
  assign o_pin_a = i_oe_a ? 1'b0 : 1'b1;
  assign o_pin_b = i_oe_b ? 1'b0 : 1'b1;
endmodule

// ---- bench/chgmon_top_tb.sv ----
// Self-checking bench for the charger supervisor top.
// Assumes the pin host model and a short charge limit of 220000 cycles.
`timescale 1ns/1ps
module chgmon_top_tb
  import chgmon_pkg::*;
;
  typedef struct packed {logic [3:0] th; logic [5:0] sp; logic [2:0] ex;} chgmon_row_s;
  logic          clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]    htrans = 2'h0;
  logic [31:0]   haddr = 32'h0, hwdata = 32'h0, rd;
  chgmon_therm_s th = 4'h5;
  chgmon_sup_s   sp = 6'h28;
  wire logic [31:0] hrdata;
  wire logic     hrdy, red, snk, src, vref, lowp, chg, pa, pb, oea, oeb, irq, hresp, psel;
  wire logic [31:0] pat = {29'h0, oea, oeb, chg};
  int            n_fail = 0, samples_checked = 0, cyc = 0, k;
  chgmon_row_s   rows [10] = '{'{4'h5, 6'h08, 3'h5}, '{4'h5, 6'h00, 3'h5},
    '{4'h9, 6'h00, 3'h6}, '{4'h1, 6'h00, 3'h6}, '{4'h5, 6'h00, 3'h5},
    '{4'h6, 6'h00, 3'h6}, '{4'h4, 6'h00, 3'h6}, '{4'h5, 6'h00, 3'h5},
    '{4'h5, 6'h20, 3'h0}, '{4'h5, 6'h00, 3'h5}};

  chgmon_top #(.P_CHG_LIMIT_CYC(64'h0000_0000_0003_5B60)) uut (
    .i_clk_sys(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .i_therm(th), .i_sup(sp),
    .o_charge_enable(chg), .o_precharge_sel(psel), .o_reduce_current(red),
    .o_probe_sink(snk), .o_probe_source(src), .o_vref_enable(vref), .o_low_power(lowp),
    .i_status_out_a(pa), .o_status_out_a(), .o_status_out_a_oe(oea),
    .i_status_out_b(pb), .o_status_out_b(), .o_status_out_b_oe(oeb), .o_irq(irq));
  chgmon_pins_host host (.i_oe_a(oea), .i_oe_b(oeb), .o_pin_a(pa), .o_pin_b(pb));

  always #2.5 clk = ~clk;

  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      n_fail++;
    end
  endtask

  // One AHB-Lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    chk("reset pins", 32'h0, pat);
    chk("reset low power", 32'h1, {31'h0, lowp});
    srst <= 1'b0;
    @(posedge clk);
    bus(1'b0, OFS_MASK, 32'h0);
    chk("mask reset", 32'h0, rd);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("okay response", 32'h0, {31'h0, hresp});
    foreach (rows[i])
    begin
      th <= rows[i].th;
      sp <= rows[i].sp;
      repeat (6) @(posedge clk);
      chk("row pins", {29'h0, rows[i].ex}, pat);
    end
    sp <= 6'h01;
    repeat (4) @(posedge clk);
    chk("reduce", 32'h1, {31'h0, red});
    bus(1'b1, OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk("inhibit", 32'h0, {31'h0, chg});
    bus(1'b1, OFS_CTRL, 32'h0);
    sp <= 6'h14;
    repeat (990) @(posedge clk);
    chk("early sink", 32'h0, {31'h0, snk});
    for (k = 0; k < 40 && snk !== 1'b1; k++) @(posedge clk);
    for (k = 0; k < 40 && snk === 1'b1; k++) @(posedge clk);
    chk("sink width", 32'h5, k);
    repeat (10) @(posedge clk);
    chk("done pins", 32'h2, pat);
    chk("masked irq", 32'h0, {31'h0, irq});
    bus(1'b0, OFS_STATE, 32'h0);
    chk("state word", 32'(ST_DONE) | (32'h1 << STA_PIN_A), rd);
    bus(1'b1, OFS_MASK, 32'h2);
    sp <= 6'h18;
    repeat (3) @(posedge clk);
    sp <= 6'h1C;
    for (k = 0; k < 1100 && src !== 1'b1; k++) @(posedge clk);
    chk("source probe", 32'h1, {31'h0, src});
    repeat (10) @(posedge clk);
    chk("absent pins", 32'h6, pat);
    chk("irq", 32'h1, {31'h0, irq});
    sp <= 6'h20;
    repeat (6) @(posedge clk);
    chk("standby pins", 32'h0, pat);
    bus(1'b1, OFS_EVT, 32'h1F);
    bus(1'b0, OFS_EVT, 32'h0);
    chk("events cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    sp <= 6'h08;
    repeat (27400) @(posedge clk);
    chk("prech running", 32'h5, pat);
    chk("prech select", 32'h1, {31'h0, psel});
    repeat (200) @(posedge clk);
    chk("prech expiry", 32'h6, pat);
    sp <= 6'h02;
    repeat (4) @(posedge clk);
    chk("shutdown", 32'h2, {29'h0, vref, lowp, oea | oeb});
    conclude();
  end
endmodule

// ---- hw/chgmon_pkg.sv ----
// Constants, types and helpers shared by the charger supervisory block.
// Assumes one 200 MHz clock and comparator levels already in that domain.
//
// What this block does
// [RQ1] Junction at about 120 C reduces charge current to hold temperature.
// [RQ2] Sense voltage outside the window halts charging and shows a fault.
// [RQ3] Sense back inside the window, with hysteresis, resumes charging by itself.
// [RQ4] Above cold threshold (900 mV) stop and flag; resume below 780 mV.
// [RQ5] Below hot threshold (225 mV) stop; resume at 248 mV.
// [RQ6] Without thermistor, board fits half the pull-up resistor instead.
// [RQ7] After end-of-charge deglitch, sink probe current for limit/54000.
// [RQ8] Output below precharge after sink: source probe, then test recharge level.
// [RQ9] Output swinging between both thresholds within one probe means no battery.
// [RQ10] Two open-collector status outputs for lamps or a host.
// [RQ11] Precharge or fast charge: first output on, second off.
// [RQ12] Current below termination, charge done: first off, second on.
// [RQ13] Input below battery plus 50 mV, standby: both outputs off.
// [RQ14] Temperature fault, battery absent or timer expiry: both outputs on.
// [RQ15] Shutdown pin grounded runs; floating shuts down and turns reference off.
// [RQ16] End of charge only after current stays low for limit/220.
// [RQ17] Precharge safety timer of limit/8; still low at expiry faults.
// [RQ18] Fault indication takes precedence over all other indications; a temperature fault shows only outside standby and shutdown.
// [RQ19] On means the open collector sinks; off leaves the pin released.
package chgmon_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam longint unsigned CLK_HZ       = 64'h0000_0000_0BEB_C200;
  localparam longint unsigned CHG_LIMIT_S  = 64'h0000_0000_0000_2A30;
  localparam longint unsigned DIV_DEGLITCH = 64'h0000_0000_0000_00DC;
  localparam longint unsigned DIV_PROBE    = 64'h0000_0000_0000_D2F0;
  localparam longint unsigned DIV_PRECH    = 64'h0000_0000_0000_0008;
  localparam int              TMR_W        = 48;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and fields
  localparam logic [7:0] OFS_EVT   = 8'h00;
  localparam logic [7:0] OFS_MASK  = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_CTRL  = 8'h0C;
  localparam int         EVT_W        = 5;
  localparam int         EVT_DONE     = 0;
  localparam int         EVT_ABSENT   = 1;
  localparam int         EVT_OVERTIME = 2;
  localparam int         EVT_TEMP     = 3;
  localparam int         EVT_STANDBY  = 4;
  localparam logic [EVT_W-1:0] EVT_RST  = 5'h00;
  localparam logic [EVT_W-1:0] MASK_RST = 5'h00;
  localparam int         CTRL_INHIBIT = 0;
  localparam logic       CTRL_RST     = 1'h0;
  localparam int         STA_COLD     = 9;
  localparam int         STA_HOT      = 10;
  localparam int         STA_ABSENT   = 11;
  localparam int         STA_REDUCE   = 12;
  localparam int         STA_PIN_A    = 13;
  localparam int         STA_PIN_B    = 14;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [8:0] {
    ST_SHDN     = 9'h001,
    ST_STANDBY  = 9'h002,
    ST_PRECH    = 9'h004,
    ST_FAST     = 9'h008,
    ST_SINK     = 9'h010,
    ST_SOURCE   = 9'h020,
    ST_ABSENT   = 9'h040,
    ST_DONE     = 9'h080,
    ST_OVERTIME = 9'h100
  } chgmon_state_e;

  // Thermistor window comparators
  typedef struct packed {
    logic above_cold;     // Sense above cold_limit_threshold
    logic below_cold_rel; // Sense below cold_limit_release
    logic below_hot;      // Sense below hot_limit_threshold
    logic above_hot_rel;  // Sense above hot_limit_release
  } chgmon_therm_s;

  // Supply, current and output comparators
  typedef struct packed {
    logic vin_low;        // Input below battery plus 50 mV
    logic below_term;     // Charge current below termination_current
    logic vout_below_pre; // Output below precharge_threshold
    logic vout_above_rch; // Output above recharge_threshold
    logic shutdown_float; // Shutdown pin left floating
    logic junction_hot;   // Junction at its regulation temperature
  } chgmon_sup_s;

  // Cycle count of limit/div, rounded up, never below one
  function automatic logic [TMR_W-1:0] chgmon_ceil_div(input longint unsigned n,
                                                       input longint unsigned d);
    longint unsigned q;
    q = (n + d - 64'h1) / d;
    if (q == 64'h0)
      q = 64'h1;
    return q[TMR_W-1:0];
  endfunction

endpackage

// ---- hw/chgmon_therm.sv ----
// Thermistor window with hysteresis and junction thermal loop request.
// Assumes comparator levels synchronous to the clock.
`timescale 1ns/1ps
module chgmon_therm
  import chgmon_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_srst,
  // Comparators
  input  wire chgmon_therm_s i_therm,
  input  wire logic          i_junction_hot,
  // Results
  output logic               o_cold_fault,
  output logic               o_hot_fault,
  output logic               o_temp_ok,
  output logic               o_reduce_current
);

  logic cold_reg;
  logic hot_reg;
  logic reduce_reg;

  // Set at the limit, release only past the hysteresis level
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      cold_reg   <= 1'b0;
      hot_reg    <= 1'b0;
      reduce_reg <= 1'b0;
    end
    else
    begin
      if (i_therm.above_cold)
        cold_reg <= 1'b1;          // RQ4
      else if (i_therm.below_cold_rel)
        cold_reg <= 1'b0;          // RQ3
      if (i_therm.below_hot)
        hot_reg <= 1'b1;           // RQ5
      else if (i_therm.above_hot_rel)
        hot_reg <= 1'b0;           // RQ3
      reduce_reg <= i_junction_hot; // RQ1
    end
  end

  // Window outputs
  assign o_cold_fault     = cold_reg;
  assign o_hot_fault      = hot_reg;
  assign o_temp_ok        = !cold_reg && !hot_reg; // RQ2
  assign o_reduce_current = reduce_reg;

endmodule

// ---- hw/chgmon_timer.sv ----
// Restartable up-counter that flags when a cycle limit is reached.
// Assumes the limit is stable while the timer runs.
`timescale 1ns/1ps
module chgmon_timer
  import chgmon_pkg::*;
#(
  parameter int W = TMR_W
)(
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  // Control
  input  wire logic         i_restart,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_limit,
  // Result
  output logic              o_expired
);

  logic [W-1:0] cnt_reg;

  // Expired once the count meets the limit
  assign o_expired = (cnt_reg >= i_limit);

  // Count while running, hold at the limit
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst || i_restart)
      cnt_reg <= '0;
    else if (i_run && !o_expired)
      cnt_reg <= cnt_reg + 1'b1;
  end

endmodule

// ---- hw/chgmon_top.sv ----
// Charger supervisor: charge state, battery probe, status pins, AHB-Lite regs.
// Assumes comparator inputs synchronous to i_clk_sys and a single AHB master.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module chgmon_top
  import chgmon_pkg::*;
#(
  parameter longint unsigned P_CHG_LIMIT_CYC = CHG_LIMIT_S * CLK_HZ
)(
  // Clock and reset
  input  wire logic          i_clk_sys,
  input  wire logic          i_srst,
  // AHB-Lite slave
  input  wire logic          i_hsel,
  input  wire logic [31:0]   i_haddr,
  input  wire logic [1:0]    i_htrans,
  input  wire logic          i_hwrite,
  input  wire logic [2:0]    i_hsize,
  input  wire logic [31:0]   i_hwdata,
  input  wire logic          i_hready,
  output logic [31:0]        o_hrdata,
  output logic               o_hreadyout,
  output logic               o_hresp,
  // Comparators
  input  wire chgmon_therm_s i_therm,
  input  wire chgmon_sup_s   i_sup,
  // Charger controls
  output logic               o_charge_enable,
  output logic               o_precharge_sel,
  output logic               o_reduce_current,
  output logic               o_probe_sink,
  output logic               o_probe_source,
  output logic               o_vref_enable,
  output logic               o_low_power,
  // Open-collector status pins
  input  wire logic          i_status_out_a,
  output logic               o_status_out_a,
  output logic               o_status_out_a_oe,
  input  wire logic          i_status_out_b,
  output logic               o_status_out_b,
  output logic               o_status_out_b_oe,
  // Interrupt
  output logic               o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Timer limits from the charge time limit; a probe's entry edge is its first cycle
  localparam logic [TMR_W-1:0] DEGL_LIM  = chgmon_ceil_div(P_CHG_LIMIT_CYC, DIV_DEGLITCH);
  localparam logic [TMR_W-1:0] PROBE_LIM = chgmon_ceil_div(P_CHG_LIMIT_CYC, DIV_PROBE) - 1'b1;
  localparam logic [TMR_W-1:0] PRECH_LIM = chgmon_ceil_div(P_CHG_LIMIT_CYC, DIV_PRECH);
  localparam logic [TMR_W-1:0] CHG_LIM   = chgmon_ceil_div(P_CHG_LIMIT_CYC, 64'h1);

  chgmon_state_e    state_reg;
  chgmon_state_e    state_next;
  logic             absent_reg;
  logic             absent_next;
  logic [EVT_W-1:0] evt_reg;
  logic [EVT_W-1:0] mask_reg;
  logic             inhibit_reg;
  logic             temp_ok_reg;
  logic             a_on_reg;
  logic             b_on_reg;
  logic             chg_en_reg;
  logic             prech_sel_reg;
  logic             sink_reg;
  logic             source_reg;
  logic             vref_reg;
  logic             irq_reg;
  logic [31:0]      hrdata_reg;
  logic             wr_pend_reg;
  logic [7:0]       wr_addr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Thermistor window and timers
  logic cold_fault;
  logic hot_fault;
  logic temp_ok;
  logic degl_exp;
  logic probe_exp;
  logic prech_exp;
  logic chg_exp;

  chgmon_therm u_therm (
    .i_clk_sys        (i_clk_sys),
    .i_srst           (i_srst),
    .i_therm          (i_therm),
    .i_junction_hot   (i_sup.junction_hot),
    .o_cold_fault     (cold_fault),
    .o_hot_fault      (hot_fault),
    .o_temp_ok        (temp_ok),
    .o_reduce_current (o_reduce_current)
  );

  // State decode shared by timers, outputs and events
  wire in_prech    = (state_reg == ST_PRECH);
  wire in_fast     = (state_reg == ST_FAST);
  wire in_probe    = (state_reg == ST_SINK) || (state_reg == ST_SOURCE);
  wire in_active   = (state_reg != ST_SHDN) && (state_reg != ST_STANDBY);
  wire charging    = (in_prech || in_fast) && temp_ok && !inhibit_reg;
  wire state_chg   = (state_next != state_reg);
  wire enter_fast  = (state_next == ST_FAST) && !in_fast;

  chgmon_timer u_degl (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_restart (!in_fast || !i_sup.below_term),
    .i_run     (charging),
    .i_limit   (DEGL_LIM),
    .o_expired (degl_exp)
  );

  chgmon_timer u_probe (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_restart (state_chg),
    .i_run     (in_probe),
    .i_limit   (PROBE_LIM),
    .o_expired (probe_exp)
  );

  chgmon_timer u_prech (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_restart (state_reg == ST_STANDBY),
    .i_run     (in_prech && charging),
    .i_limit   (PRECH_LIM),
    .o_expired (prech_exp)
  );

  chgmon_timer u_chg (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_restart (enter_fast),
    .i_run     (in_fast && charging),
    .i_limit   (CHG_LIM),
    .o_expired (chg_exp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Charge state sequence
  always_comb
  begin
    state_next = state_reg;
    if (i_sup.shutdown_float)
      state_next = ST_SHDN;                                       // RQ15
    else if (i_sup.vin_low)
      state_next = ST_STANDBY;                                    // RQ13
    else
    begin
      case (state_reg)
        ST_SHDN:
          state_next = ST_STANDBY;
        ST_STANDBY:
          state_next = i_sup.vout_below_pre ? ST_PRECH : ST_FAST;
        ST_PRECH:
          if (!i_sup.vout_below_pre)
            state_next = ST_FAST;
          else if (prech_exp)
            state_next = ST_OVERTIME;                             // RQ17
        ST_FAST:
          if (chg_exp)
            state_next = ST_OVERTIME;
          else if (degl_exp)
            state_next = ST_SINK;                                 // RQ16 RQ7
        ST_SINK:
          if (probe_exp)
          begin
            if (i_sup.vout_below_pre)
              state_next = ST_SOURCE;                             // RQ8
            else
              state_next = absent_reg ? ST_STANDBY : ST_DONE;
          end
        ST_SOURCE:
          if (probe_exp)
            state_next = i_sup.vout_above_rch ? ST_ABSENT : ST_PRECH; // RQ9
        ST_ABSENT:
          state_next = ST_SINK;
        ST_DONE:
          if (!i_sup.vout_above_rch)
            state_next = ST_FAST;
        ST_OVERTIME:
          state_next = ST_OVERTIME;
        default:
          state_next = ST_SHDN;
      endcase
    end
  end

  // Absent flag holds across the repeated probe loop
  always_comb
  begin
    absent_next = absent_reg;
    if (state_next == ST_ABSENT)
      absent_next = 1'b1;
    else if ((state_next == ST_STANDBY) || (state_next == ST_SHDN) ||
             (state_next == ST_PRECH) || (state_next == ST_FAST))
      absent_next = 1'b0;
  end

  // Status indication with faults first
  wire fault_ind = absent_reg || (state_reg == ST_ABSENT) ||
                   (state_reg == ST_OVERTIME) ||
                   (!temp_ok && in_active);                        // RQ14 RQ2
  wire a_on_next = fault_ind || in_prech || in_fast;                // RQ18 RQ11
  wire b_on_next = fault_ind || in_probe || (state_reg == ST_DONE); // RQ18 RQ12

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite decode
  wire        addr_ph   = i_hsel && i_htrans[1] && i_hready;
  wire [7:0]  rd_ofs    = i_haddr[7:0];
  wire        wr_evt    = wr_pend_reg && (wr_addr_reg == OFS_EVT);
  wire        wr_mask   = wr_pend_reg && (wr_addr_reg == OFS_MASK);
  wire        wr_ctrl   = wr_pend_reg && (wr_addr_reg == OFS_CTRL);
  wire [31:0] state_word = {17'h00000, i_status_out_b, i_status_out_a,
                            o_reduce_current, absent_reg, hot_fault,
                            cold_fault, state_reg};
  wire [31:0] rd_value  = (rd_ofs == OFS_EVT)   ? {27'h0000000, evt_reg}  :
                          (rd_ofs == OFS_MASK)  ? {27'h0000000, mask_reg} :
                          (rd_ofs == OFS_STATE) ? state_word :
                          (rd_ofs == OFS_CTRL)  ? {31'h00000000, inhibit_reg} :
                          32'h00000000;

  // Events: set wins over a write-one clear
  wire [EVT_W-1:0] evt_set;
  assign evt_set[EVT_DONE]     = state_chg && (state_next == ST_DONE);
  assign evt_set[EVT_ABSENT]   = state_chg && (state_next == ST_ABSENT) && !absent_reg;
  assign evt_set[EVT_OVERTIME] = state_chg && (state_next == ST_OVERTIME);
  assign evt_set[EVT_TEMP]     = temp_ok_reg && !temp_ok;
  assign evt_set[EVT_STANDBY]  = state_chg && (state_next == ST_STANDBY) && in_active;
  wire [EVT_W-1:0] evt_clr  = wr_evt ? i_hwdata[EVT_W-1:0] : EVT_RST;
  wire [EVT_W-1:0] evt_next = (evt_reg & ~evt_clr) | evt_set;

  // Bus phase tracking and read data
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= addr_ph && i_hwrite;
      if (addr_ph)
        wr_addr_reg <= i_haddr[7:0];
      if (addr_ph && !i_hwrite)
        hrdata_reg <= rd_value;
    end
  end

  // Software registers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      evt_reg     <= EVT_RST;
      mask_reg    <= MASK_RST;
      inhibit_reg <= CTRL_RST;
      irq_reg     <= 1'b0;
    end
    else
    begin
      evt_reg <= evt_next;
      irq_reg <= |(evt_next & mask_reg);
      if (wr_mask)
        mask_reg <= i_hwdata[EVT_W-1:0];
      if (wr_ctrl)
        inhibit_reg <= i_hwdata[CTRL_INHIBIT];
    end
  end

  // Charger state, flags and output flops
  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state_reg     <= ST_SHDN;
      absent_reg    <= 1'b0;
      temp_ok_reg   <= 1'b1;
      a_on_reg      <= 1'b0;
      b_on_reg      <= 1'b0;
      chg_en_reg    <= 1'b0;
      prech_sel_reg <= 1'b0;
      sink_reg      <= 1'b0;
      source_reg    <= 1'b0;
      vref_reg      <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      absent_reg    <= absent_next;
      temp_ok_reg   <= temp_ok;
      a_on_reg      <= a_on_next;
      b_on_reg      <= b_on_next;
      chg_en_reg    <= charging;                         // RQ2 RQ3
      prech_sel_reg <= (state_next == ST_PRECH);
      sink_reg      <= (state_next == ST_SINK);          // RQ7
      source_reg    <= (state_next == ST_SOURCE);        // RQ8
      vref_reg      <= (state_next != ST_SHDN);          // RQ15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_hrdata          = hrdata_reg;
  assign o_hreadyout       = 1'b1;
  assign o_hresp           = 1'b0;
  assign o_charge_enable   = chg_en_reg;
  assign o_precharge_sel   = prech_sel_reg;
  assign o_probe_sink      = sink_reg;
  assign o_probe_source    = source_reg;
  assign o_vref_enable     = vref_reg;
  assign o_low_power       = !vref_reg;
  assign o_status_out_a    = 1'b0;     // RQ19
  assign o_status_out_b    = 1'b0;     // RQ19
  assign o_status_out_a_oe = a_on_reg; // RQ10
  assign o_status_out_b_oe = b_on_reg; // RQ10
  assign o_irq             = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  chk_junction_reduce: assert property (i_sup.junction_hot |=> o_reduce_current) // RQ1
    else $error("junction hot did not reduce current");
  chk_window_halt: assert property (!temp_ok |=> !o_charge_enable) // RQ2
    else $error("charging not halted outside window");
  chk_window_resume: assert property ($rose(temp_ok) && (in_prech || in_fast) &&
      !inhibit_reg && (state_next == state_reg) |=> o_charge_enable) // RQ3
    else $error("charging did not resume");
  chk_cold_trip: assert property (i_therm.above_cold |=> !temp_ok ##0 cold_fault) // RQ4
    else $error("cold limit not flagged");
  chk_hot_hold: assert property (hot_fault && !i_therm.above_hot_rel |=> hot_fault) // RQ5
    else $error("hot limit released early");
  chk_sink_probe: assert property ((state_reg == ST_SINK) |-> o_probe_sink && !o_probe_source) // RQ7
    else $error("sink probe not applied");
  chk_source_after: assert property ((state_reg == ST_SINK) && probe_exp &&
      i_sup.vout_below_pre && !i_sup.vin_low && !i_sup.shutdown_float
      |=> o_probe_source ##0 (state_reg == ST_SOURCE)) // RQ8
    else $error("source probe missed");
  chk_absent_flag: assert property ((state_reg == ST_SOURCE) && probe_exp &&
      i_sup.vout_above_rch && !i_sup.vin_low && !i_sup.shutdown_float
      |=> absent_reg ##1 (o_status_out_a_oe && o_status_out_b_oe)) // RQ9 RQ14
    else $error("absent battery not reported");
  chk_status_charge: assert property ((in_prech || in_fast) && !fault_ind
      |=> o_status_out_a_oe && !o_status_out_b_oe) // RQ11
    else $error("charge indication wrong");
  chk_status_done: assert property ((state_reg == ST_DONE) && !fault_ind
      |=> !o_status_out_a_oe && o_status_out_b_oe) // RQ12
    else $error("done indication wrong");
  chk_status_standby: assert property ((state_reg == ST_STANDBY) && !absent_reg
      |=> !o_status_out_a_oe && !o_status_out_b_oe) // RQ13
    else $error("standby indication wrong");
  chk_fault_first: assert property ((state_reg == ST_OVERTIME) |=>
      o_status_out_a_oe && o_status_out_b_oe) // RQ18
    else $error("fault lost precedence");
  chk_shutdown_vref: assert property (i_sup.shutdown_float |=> !o_vref_enable ##0 o_low_power) // RQ15
    else $error("shutdown left reference on");
  chk_deglitch_done: assert property ((state_reg == ST_SINK) && $past(in_fast)
      |-> $past(degl_exp)) // RQ16
    else $error("end of charge without deglitch");
  chk_prech_timeout: assert property (in_prech && prech_exp && i_sup.vout_below_pre &&
      !i_sup.vin_low && !i_sup.shutdown_float |=> (state_reg == ST_OVERTIME)) // RQ17
    else $error("precharge timeout missed");
  chk_pin_sinks: assert property (!o_status_out_a && !o_status_out_b) // RQ19
    else $error("status pin driven high");

  cov_done: cover property ((state_reg == ST_FAST) ##1 (state_reg == ST_SINK));
  cov_absent: cover property ((state_reg == ST_SOURCE) ##1 (state_reg == ST_ABSENT));
  cov_temp_pause: cover property (in_fast && $fell(temp_ok));
  cov_overtime: cover property ($rose(state_reg == ST_OVERTIME));

endmodule
